// ===== core/public_key_unit_pkg.sv
// Constants, register map and types of the public key unit register block
// Behaviour
// - B, A, N memories decoded, host read/write
// - Exponent, control, program counter are read/write
// - Status register decoded and read-only
// - Interrupt mask register is read/write
// - Write to clear location drops interrupt flag
// - Modulus and exponent size registers read/write
// - Each register takes one full 32-bit slot
// - Identifier register returns fixed version code
// - Dynamic control bits self-clear after one cycle
// - Unimplemented control bits read as zero
// - Control bits 0-1 select modulus sub-memory
// - Control bits 2-3 select B sub-memory
// - Control bits 4-5 select A sub-memory
// - Each memory: four sub-memories, 32x16 bits
// - Unit moves block pointers itself when running
// - Host-set block pointers are honoured
// - Software reset restores state, clears memories
// - Interrupt enable gates output, not status flag
// - Start runs until stop; RAM access ignored
package public_key_unit_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_B_MEM      = 12'ha00;
  localparam logic [11:0] IDX_A_MEM      = 12'ha40;
  localparam logic [11:0] IDX_N_MEM      = 12'ha80;
  localparam logic [11:0] IDX_EXPONENT   = 12'hb00;
  localparam logic [11:0] IDX_CONTROL    = 12'hb01;
  localparam logic [11:0] IDX_STATUS     = 12'hb02;
  localparam logic [11:0] IDX_INT_MASK   = 12'hb03;
  localparam logic [11:0] IDX_PC         = 12'hb05;
  localparam logic [11:0] IDX_INT_CLEAR  = 12'hb06;
  localparam logic [11:0] IDX_MOD_SIZE   = 12'hb07;
  localparam logic [11:0] IDX_EXP_SIZE   = 12'hb08;
  localparam logic [11:0] IDX_VERSION    = 12'hb09;
  localparam int          ADDR_W         = 14;

  // Memory geometry
  localparam int          SUB_COUNT      = 4;
  localparam int          SUB_DEPTH      = 32;
  localparam int          WORD_W         = 16;

  // Control field positions
  localparam int          CTL_N_PTR_LO   = 0;
  localparam int          CTL_B_PTR_LO   = 2;
  localparam int          CTL_A_PTR_LO   = 4;
  localparam int          CTL_BIN_FIELD  = 7;
  localparam int          CTL_PROJ_OUT   = 8;
  localparam int          CTL_MONT_SEL   = 9;
  localparam int          CTL_SOFT_RST   = 10;
  localparam int          CTL_INT_EN     = 11;
  localparam int          CTL_START      = 12;
  localparam int          CTL_CURVE      = 13;
  localparam logic [15:0] CTL_IMPL_MASK  = 16'h3fbf;
  localparam logic [15:0] CTL_DYN_MASK   = 16'h1400;
  localparam logic [15:0] CTL_RESET      = 16'h0000;

  // Status field positions
  localparam int          ST_DONE        = 0;
  localparam int          ST_IRQ         = 1;
  localparam int          ST_BUSY        = 2;
  localparam int          ST_CLEARING    = 3;

  // Interrupt mask bit gating the completion event
  localparam int          MASK_DONE      = 0;
  localparam logic [31:0] WORD_RESET     = 32'h0000_0000;

  // Identifier; value is arbitrary
  localparam logic [31:0] VERSION_CODE   = 32'h0000_0a5c;

  typedef enum logic [3:0] {
    REG_NONE     = 4'b0000,
    REG_B_MEM    = 4'b0001,
    REG_A_MEM    = 4'b0010,
    REG_N_MEM    = 4'b0011,
    REG_EXPONENT = 4'b0100,
    REG_CONTROL  = 4'b0101,
    REG_STATUS   = 4'b0110,
    REG_INT_MASK = 4'b0111,
    REG_PC       = 4'b1000,
    REG_INT_CLR  = 4'b1001,
    REG_MOD_SIZE = 4'b1010,
    REG_EXP_SIZE = 4'b1011,
    REG_VERSION  = 4'b1100
  } reg_sel_t;

endpackage

// ===== core/public_key_unit_registers.sv
// APB register block and operand memories of the public key unit
`timescale 1ns/100ps
`default_nettype none
module public_key_unit_registers
  import public_key_unit_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              engine_halt,
  input  wire logic              engine_ptr_we,
  input  wire logic [5:0]        engine_ptr,
  input  wire logic              engine_pc_we,
  input  wire logic [31:0]       engine_pc,
  output var  logic              engine_go,
  output var  logic              engine_running,
  output var  logic [15:0]       unit_control,
  output var  logic [31:0]       exponent_value,
  output var  logic [31:0]       program_counter,
  output var  logic [31:0]       modulus_size,
  output var  logic [31:0]       exponent_size,
  output var  logic              irq
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [31:0] exponent;
    logic [31:0] mask;
    logic [31:0] pc;
    logic [31:0] mod_size;
    logic [31:0] exp_size;
    logic        done;
    logic        irq_flag;
    logic        running;
    logic        clearing;
    logic [4:0]  clr_idx;
    logic        go;
    logic        ready;
    logic        err;
    logic [31:0] rdata;
    logic        irq;
  } state_t;

  state_t state;
  state_t next_state;

  // Operand memories: [memory][sub-memory][location], 0=B 1=A 2=N
  logic [WORD_W-1:0] mem [3][SUB_COUNT][SUB_DEPTH];

  // Address decode, shared by the setup read and the access write
  function automatic reg_sel_t decode(input logic [11:0] idx);
    reg_sel_t sel;
    sel = REG_NONE;
    if (idx[11:6] == IDX_B_MEM[11:6]) begin
      sel = REG_B_MEM;
    end else if (idx[11:6] == IDX_A_MEM[11:6]) begin
      sel = REG_A_MEM;
    end else if (idx[11:6] == IDX_N_MEM[11:6]) begin
      sel = REG_N_MEM;
    end else begin
      unique case (idx)
        IDX_EXPONENT:  sel = REG_EXPONENT;
        IDX_CONTROL:   sel = REG_CONTROL;
        IDX_STATUS:    sel = REG_STATUS;
        IDX_INT_MASK:  sel = REG_INT_MASK;
        IDX_PC:        sel = REG_PC;
        IDX_INT_CLEAR: sel = REG_INT_CLR;
        IDX_MOD_SIZE:  sel = REG_MOD_SIZE;
        IDX_EXP_SIZE:  sel = REG_EXP_SIZE;
        IDX_VERSION:   sel = REG_VERSION;
        default:       sel = REG_NONE;
      endcase
    end
    return sel;
  endfunction

  // Sub-memory chosen by the block pointer of a memory
  function automatic logic [1:0] block_of(input logic [15:0] ctl, input logic [1:0] m);
    logic [1:0] blk;
    blk = ctl[CTL_B_PTR_LO +: 2];
    if (m == 2'd1) begin
      blk = ctl[CTL_A_PTR_LO +: 2];
    end else if (m == 2'd2) begin
      blk = ctl[CTL_N_PTR_LO +: 2];
    end
    return blk;
  endfunction

  logic [11:0] idx;
  reg_sel_t    sel;
  logic        is_mem;
  logic [1:0]  mem_id;
  logic        mem_open;
  logic        access_done;
  logic        host_wr;
  logic [15:0] ctrl_rd;
  logic [31:0] status_rd;

  // Transfer classification
  always_comb begin
    idx         = paddr[ADDR_W-1:2];
    sel         = decode(idx);
    is_mem      = (sel == REG_B_MEM) || (sel == REG_A_MEM) || (sel == REG_N_MEM);
    mem_id      = (sel == REG_A_MEM) ? 2'd1 : ((sel == REG_N_MEM) ? 2'd2 : 2'd0);
    // Upper half of each window aliases nothing; only 32 words are live
    mem_open    = is_mem && !idx[5] && !state.running && !state.clearing;
    access_done = psel && penable && state.ready;
    host_wr     = access_done && pwrite;
    ctrl_rd     = state.ctrl & CTL_IMPL_MASK;
    status_rd   = WORD_RESET;
    status_rd[ST_DONE]     = state.done;
    status_rd[ST_IRQ]      = state.irq_flag;
    status_rd[ST_BUSY]     = state.running;
    status_rd[ST_CLEARING] = state.clearing;
  end

  // Next state of the whole block
  always_comb begin
    next_state       = state;
    next_state.ctrl  = state.ctrl & ~CTL_DYN_MASK;
    next_state.go    = 1'b0;
    next_state.ready = psel && !penable;               // one access cycle, no wait
    next_state.err   = 1'b0;
    next_state.rdata = WORD_RESET;

    // Read data and error captured in the setup cycle
    if (psel && !penable) begin
      next_state.err = (sel == REG_NONE);
      if (!pwrite) begin
        unique case (sel)
          REG_B_MEM, REG_A_MEM, REG_N_MEM: begin
            if (mem_open) begin
              next_state.rdata = {16'h0000, mem[mem_id][block_of(state.ctrl, mem_id)][idx[4:0]]};
            end
          end
          REG_EXPONENT: next_state.rdata = state.exponent;
          REG_CONTROL:  next_state.rdata = {16'h0000, ctrl_rd};
          REG_STATUS:   next_state.rdata = status_rd;
          REG_INT_MASK: next_state.rdata = state.mask;
          REG_PC:       next_state.rdata = state.pc;
          REG_INT_CLR:  next_state.rdata = WORD_RESET;
          REG_MOD_SIZE: next_state.rdata = state.mod_size;
          REG_EXP_SIZE: next_state.rdata = state.exp_size;
          REG_VERSION:  next_state.rdata = VERSION_CODE;
          REG_NONE:     next_state.rdata = WORD_RESET;
        endcase
      end
    end

    // Engine side: pointer and counter updates while running
    if (state.running && engine_ptr_we) begin
      next_state.ctrl[5:0] = engine_ptr;
    end
    if (state.running && engine_pc_we) begin
      next_state.pc = engine_pc;
    end

    // Memory clear walk, one location of every sub-memory per cycle
    if (state.clearing) begin
      next_state.clr_idx = state.clr_idx + 5'd1;
      if (state.clr_idx == 5'(SUB_DEPTH - 1)) begin
        next_state.clearing = 1'b0;
      end
    end

    // Interrupt flag clear; a completion in the same cycle wins below
    if (host_wr && sel == REG_INT_CLR) begin
      next_state.irq_flag = 1'b0;
    end
    if (state.running && engine_halt) begin
      next_state.running = 1'b0;
      next_state.done    = 1'b1;
      if (state.mask[MASK_DONE]) begin
        next_state.irq_flag = 1'b1;
      end
    end

    // Host writes at the access edge
    if (host_wr) begin
      unique case (sel)
        REG_EXPONENT: next_state.exponent = pwdata;
        REG_INT_MASK: next_state.mask     = pwdata;
        REG_PC:       next_state.pc       = pwdata;
        REG_MOD_SIZE: next_state.mod_size = pwdata;
        REG_EXP_SIZE: next_state.exp_size = pwdata;
        REG_CONTROL: begin
          next_state.ctrl = pwdata[15:0] & CTL_IMPL_MASK;
          if (pwdata[CTL_SOFT_RST]) begin
            // Everything back to reset, then the memory clear walk
            next_state.ctrl     = CTL_RESET;
            next_state.ctrl[CTL_SOFT_RST] = 1'b1;
            next_state.exponent = WORD_RESET;
            next_state.mask     = WORD_RESET;
            next_state.pc       = WORD_RESET;
            next_state.mod_size = WORD_RESET;
            next_state.exp_size = WORD_RESET;
            next_state.done     = 1'b0;
            next_state.irq_flag = 1'b0;
            next_state.running  = 1'b0;
            next_state.clearing = 1'b1;
            next_state.clr_idx  = 5'd0;
          end else if (pwdata[CTL_START] && !state.clearing) begin
            next_state.running = 1'b1;
            next_state.go      = 1'b1;
            next_state.done    = 1'b0;
          end
        end
        // Status, identifier and memory words need no register update
        default: begin
        end
      endcase
    end

    next_state.irq = next_state.irq_flag && next_state.ctrl[CTL_INT_EN];
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= '0;
      state.ctrl     <= CTL_RESET;
      state.exponent <= WORD_RESET;
      state.mask     <= WORD_RESET;
      state.pc       <= WORD_RESET;
      state.mod_size <= WORD_RESET;
      state.exp_size <= WORD_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Memory writes; no reset on the array, the clear walk zeroes it
  always_ff @(posedge pclk) begin
    if (state.clearing) begin
      for (int m = 0; m < 3; m++) begin
        for (int s = 0; s < SUB_COUNT; s++) begin
          mem[m][s][state.clr_idx] <= 16'h0000;
        end
      end
    end else if (host_wr && mem_open) begin
      mem[mem_id][block_of(state.ctrl, mem_id)][idx[4:0]] <= pwdata[15:0];
    end
  end

  // Ports straight from flip-flops
  always_comb begin
    prdata          = state.rdata;
    pready          = state.ready;
    pslverr         = state.err;
    engine_go       = state.go;
    engine_running  = state.running;
    unit_control    = state.ctrl;
    exponent_value  = state.exponent;
    program_counter = state.pc;
    modulus_size    = state.mod_size;
    exponent_size   = state.exp_size;
    irq             = state.irq;
  end

  // Checks
  chk_dyn_bits_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (state.ctrl & CTL_DYN_MASK) != 16'h0000 |=> (state.ctrl & CTL_DYN_MASK) == 16'h0000)
    else $error("dynamic control bit held longer than one cycle");

  chk_ctrl_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && sel == REG_CONTROL |=> (prdata & ~{16'h0000, CTL_IMPL_MASK}) == 32'h0)
    else $error("unimplemented control bit read as one");

  chk_version_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && sel == REG_VERSION |=> prdata == VERSION_CODE)
    else $error("identifier read returned wrong code");

  chk_status_ro: assert property (@(posedge pclk) disable iff (!presetn)
    host_wr && sel == REG_STATUS && !engine_halt |=> $stable(state.done))
    else $error("status write changed done flag");

  chk_clear_irq: assert property (@(posedge pclk) disable iff (!presetn)
    host_wr && sel == REG_INT_CLR && !(state.running && engine_halt) |=> !state.irq_flag ##1 !irq)
    else $error("interrupt clear did not drop flag");

  chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> state.irq_flag && state.ctrl[CTL_INT_EN])
    else $error("interrupt output active while disabled");

  chk_soft_reset: assert property (@(posedge pclk) disable iff (!presetn)
    host_wr && sel == REG_CONTROL && pwdata[CTL_SOFT_RST]
      |=> program_counter == 32'h0 && !engine_running && state.clearing ##32 !state.clearing)
    else $error("software reset sequence wrong");

  chk_start_run: assert property (@(posedge pclk) disable iff (!presetn)
    host_wr && sel == REG_CONTROL && pwdata[CTL_START] && !pwdata[CTL_SOFT_RST] && !state.clearing
      |=> engine_go && engine_running ##1 !engine_go)
    else $error("start did not begin execution");

  chk_ram_locked: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && is_mem && state.running |=> prdata == 32'h0)
    else $error("memory read served while running");

  chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("access phase not answered in one cycle");

  cov_soft_reset: cover property (@(posedge pclk) disable iff (!presetn)
    host_wr && sel == REG_CONTROL && pwdata[CTL_SOFT_RST]);
  cov_run_done: cover property (@(posedge pclk) disable iff (!presetn)
    engine_go ##[1:50] (state.running && engine_halt));
  cov_irq_out: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  cov_mem_block3: cover property (@(posedge pclk) disable iff (!presetn)
    host_wr && mem_open && block_of(state.ctrl, mem_id) == 2'd3);

endmodule
`default_nettype wire

// ===== verif/engine_model.sv
// Behavioural execution engine that answers start pulses
`timescale 1ns/100ps
`default_nettype none
module engine_model #(
  parameter int RUN_CYCLES = 20
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        engine_go,
  input  wire logic        engine_running,
  output var  logic        engine_halt,
  output var  logic        engine_ptr_we,
  output var  logic [5:0]  engine_ptr,
  output var  logic        engine_pc_we,
  output var  logic [31:0] engine_pc
);
  int count;
  logic mid;

  // Midway point of a run, where the pointers and counter move
  assign mid = (count == RUN_CYCLES / 2);

  // Fixed program length; idle data lines toggle every cycle so stale values keep changing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count         <= 0;
      engine_halt   <= 1'b0;
      engine_ptr_we <= 1'b0;
      engine_ptr    <= 6'h00;
      engine_pc_we  <= 1'b0;
      engine_pc     <= 32'h0000_0000;
    end else begin
      count         <= engine_go ? RUN_CYCLES : (count > 0 ? count - 1 : 0);
      engine_halt   <= engine_running && count == 1;  // Halt as the count reaches zero
      engine_ptr_we <= engine_running && mid;
      engine_ptr    <= mid ? 6'h1b : ~engine_ptr;
      engine_pc_we  <= engine_running && mid;
      engine_pc     <= mid ? 32'h0000_0040 : ~engine_pc;
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking testbench of the public key unit register block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import public_key_unit_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  wire  [31:0] prdata;
  wire         pready, pslverr, engine_halt, engine_ptr_we, engine_pc_we;
  wire  [5:0]  engine_ptr;
  wire  [31:0] engine_pc;
  wire         engine_go, engine_running, irq;
  wire  [15:0] unit_control;
  wire  [31:0] exponent_value, program_counter, modulus_size, exponent_size;
  logic [31:0] rd;
  logic        err;
  int          miscompares = 0;
  int          checked = 0;

  // 250 MHz clock
  always #2 pclk = ~pclk;

  public_key_unit_registers i_public_key_unit_registers (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .engine_halt(engine_halt),
    .engine_ptr_we(engine_ptr_we), .engine_ptr(engine_ptr),
    .engine_pc_we(engine_pc_we), .engine_pc(engine_pc),
    .engine_go(engine_go), .engine_running(engine_running),
    .unit_control(unit_control), .exponent_value(exponent_value),
    .program_counter(program_counter), .modulus_size(modulus_size),
    .exponent_size(exponent_size), .irq(irq));

  engine_model i_engine_model (
    .pclk(pclk), .presetn(presetn), .engine_go(engine_go),
    .engine_running(engine_running), .engine_halt(engine_halt),
    .engine_ptr_we(engine_ptr_we), .engine_ptr(engine_ptr),
    .engine_pc_we(engine_pc_we), .engine_pc(engine_pc));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp_v);
    checked++;
    if (seen !== exp_v) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp_v, seen);
    end
  endtask

  // One APB transfer; answer taken at the rising edge that samples pready high
  task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        miscompares++;
        report_and_stop();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rdchk(input string what, input logic [11:0] idx, input logic [31:0] exp_v);
    xfer(1'b0, idx, 32'h0000_0000);
    check(what, rd, exp_v);
  endtask

  // Poll status with a bounded number of reads
  task automatic wait_status(input string what, input logic [31:0] want);
    int n;
    n = 0;
    do begin
      xfer(1'b0, IDX_STATUS, 32'h0000_0000);
      n++;
    end while (rd !== want && n < 40);
    check(what, rd, want);
    if (n >= 40) report_and_stop();
  endtask

  task automatic t_defaults();
    rdchk("control", IDX_CONTROL, 32'h0000_0000);
    rdchk("version", IDX_VERSION, VERSION_CODE);
    wr(IDX_STATUS, 32'hffff_ffff);
    rdchk("status", IDX_STATUS, 32'h0000_0000);
    rdchk("clear loc", IDX_INT_CLEAR, 32'h0000_0000);
    xfer(1'b0, 12'hb04, 32'h0000_0000);
    check("unmapped", {31'h0, err}, 32'h0000_0001);
    $display("test defaults done");
  endtask

  task automatic t_registers();
    logic [11:0] regs [5] = '{IDX_EXPONENT, IDX_INT_MASK, IDX_PC, IDX_MOD_SIZE, IDX_EXP_SIZE};
    for (int i = 0; i < 5; i++) wr(regs[i], 32'h5a00_0000 | 32'(i));
    for (int i = 0; i < 5; i++) rdchk("rw reg", regs[i], 32'h5a00_0000 | 32'(i));
    check("exp port", exponent_value, 32'h5a00_0000);
    check("pc port", program_counter, 32'h5a00_0002);
    check("mod size port", modulus_size, 32'h5a00_0003);
    check("exp size port", exponent_size, 32'h5a00_0004);
    wr(IDX_CONTROL, 32'hffff_ebbf);
    rdchk("control", IDX_CONTROL, 32'h0000_2bbf);
    check("control port", {16'h0, unit_control}, 32'h0000_2bbf);
    wr(IDX_CONTROL, 32'h0000_0000);
    $display("test registers done");
  endtask

  // Pointers differ per memory so each block is reached independently
  task automatic t_memory();
    logic [11:0] mems [3] = '{IDX_B_MEM, IDX_A_MEM, IDX_N_MEM};
    int b [3];
    for (int pass = 0; pass < 2; pass++) begin
      for (int p = 0; p < 4; p++) begin
        b = '{(p + 1) % 4, p, (p + 2) % 4};
        wr(IDX_CONTROL, 32'(b[2] | (b[0] << 2) | (p << 4)));
        for (int m = 0; m < 3; m++) begin
          if (pass == 0) wr(mems[m] + 12'h01f, 32'hffff_0000 | 32'(m * 16 + b[m] + 1));
          else rdchk("memory", mems[m] + 12'h01f, 32'(m * 16 + b[m] + 1));
        end
      end
    end
    wr(IDX_CONTROL, 32'h0000_0000);
    $display("test memory done");
  endtask

  task automatic t_run(input logic ie);
    wr(IDX_INT_MASK, 32'h0000_0001);
    wr(IDX_CONTROL, {19'h0, 1'b1, ie, 11'h000});
    rdchk("busy", IDX_STATUS, 32'h0000_0004);
    check("running pin", {31'h0, engine_running}, 32'h0000_0001);
    rdchk("ram in run", IDX_B_MEM + 12'h01f, 32'h0000_0000);
    wait_status("done", 32'h0000_0003);
    check("stopped pin", {31'h0, engine_running}, 32'h0000_0000);
    check("irq pin", {31'h0, irq}, {31'h0, ie});
    rdchk("ctrl after", IDX_CONTROL, {19'h0, 1'b0, ie, 5'h00, 6'h1b});
    rdchk("pc after", IDX_PC, 32'h0000_0040);
    wr(IDX_INT_CLEAR, 32'h0000_0000);
    rdchk("cleared", IDX_STATUS, 32'h0000_0001);
    check("irq low", {31'h0, irq}, 32'h0000_0000);
    wr(IDX_CONTROL, 32'h0000_0000);
    $display("test run done");
  endtask

  task automatic t_soft_reset();
    wr(IDX_EXPONENT, 32'h1234_5678);
    wr(IDX_CONTROL, 32'h0000_0400);
    rdchk("clearing", IDX_STATUS, 32'h0000_0008);
    wait_status("clear end", 32'h0000_0000);
    check("pc zeroed", program_counter, 32'h0000_0000);
    check("exp port zeroed", exponent_value, 32'h0000_0000);
    rdchk("exponent", IDX_EXPONENT, 32'h0000_0000);
    rdchk("mask", IDX_INT_MASK, 32'h0000_0000);
    rdchk("control", IDX_CONTROL, 32'h0000_0000);
    rdchk("mem wiped", IDX_B_MEM + 12'h01f, 32'h0000_0000);
    $display("test soft reset done");
  endtask

  // Reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_defaults();
    t_registers();
    t_memory();
    t_run(1'b1);
    t_run(1'b0);
    t_soft_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
